// >>> bench/tb.sv
// self-checking bench of the timer output, prescale and port direction block
`timescale 1ns/1ps
`include "tpc_cfg.svh"
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin bad_count++; \
  $display("ERROR t=%0t got %0h expected %0h", $time, (g), (e)); end end
module tb;
  // ==========================================================================
  // stimulus, observation and model state
  logic        ref_clk_in = 1'b0;
  logic        rst_n_in   = 1'b0;
  logic [17:0] adr        = 18'h0;
  logic        rd         = 1'b0;
  logic        wr         = 1'b0;
  logic [31:0] wd         = 32'h0;
  logic [31:0] rdata;
  logic [1:0]  run        = 2'h0;
  logic        m0         = 1'b0;
  logic        m1         = 1'b0;
  logic        pin0       = 1'b0;
  logic        pin1       = 1'b0;
  logic [31:0] q_rd;
  logic        wreq, tick, clrst, osm, irq0, irq1, e0, e1, tout;
  logic [1:0]  oe_n;
  int          bad_count, total_checks, n_tick, n_e0, n_e1, n_cs;
  int          toc_m = 0;
  int          lvl_m = 0;
  tpc_timer_out_ctrl dut (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
    .avs_address_in(adr), .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wd),
    .avs_byteenable_in(4'hf), .avs_readdata_out(q_rd), .avs_waitrequest_out(wreq),
    .run_mode_in(run), .match0_in(m0), .match1_in(m1), .count_tick_out(tick),
    .counter_clear_start_out(clrst), .oneshot_mode_out(osm), .match0_irq_out(irq0),
    .match1_irq_out(irq1), .in0_edge_out(e0), .in1_edge_out(e1),
    .timer_in0_pin_in(pin0), .timer_in1_pin_in(pin1), .timer_out_pin_out(tout),
    .port_oe_n_out(oe_n));
  always #5 ref_clk_in = ~ref_clk_in;
  // pulse counters; sampled mid-cycle so a clear on the rising edge never races them
  always @(negedge ref_clk_in) begin
    n_tick += (tick === 1'b1);
    n_e0   += (e0 === 1'b1);
    n_e1   += (e1 === 1'b1);
    n_cs   += (clrst === 1'b1);
  end
  // ==========================================================================
  // verdict
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // one avalon transfer; held until waitrequest is sampled low
  task automatic xfer(input logic w, input logic [15:0] idx, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge ref_clk_in);
    adr <= {idx, 2'b00};
    wd  <= {24'h0, d};
    wr  <= w;
    rd  <= ~w;
    do begin
      @(posedge ref_clk_in);
      n++;
    end while (wreq !== 1'b0 && n < 50);
    rdata = q_rd;
    if (n >= 50) begin
      bad_count++;
      $display("ERROR t=%0t bus transfer timed out", $time);
    end
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  task automatic rd_chk(input logic [15:0] idx, input logic [7:0] e);
    xfer(1'b0, idx, 8'h0);
    `CHK(rdata, {24'h0, e})
  endtask
  task automatic clr();
    @(posedge ref_clk_in);
    n_tick = 0; n_e0 = 0; n_e1 = 0; n_cs = 0;
  endtask
  // change run mode, let the pipeline settle
  task automatic go(input logic [1:0] m);
    @(posedge ref_clk_in);
    run <= m;
    repeat (12) @(posedge ref_clk_in);
  endtask
  // each level is held far longer than two peripheral cycles
  task automatic pins(input logic v);
    @(posedge ref_clk_in);
    pin0 <= v;
    pin1 <= v;
    repeat (12) @(posedge ref_clk_in);
  endtask
  // output control write with model update; triggers read back as 0
  task automatic wr_toc(input logic [7:0] d);
    xfer(1'b1, `TPC_IDX_OUT_CTRL, d);
    if (run == 2'h0) begin
      toc_m = d & 8'h33;
      if (d[3:2] == 2'b10) lvl_m = 1;
      if (d[3:2] == 2'b01) lvl_m = 0;
    end else toc_m = (toc_m & 8'h23) | (d & 8'h10);
    repeat (2) @(posedge ref_clk_in);
    #1 `CHK(tout, 1'((toc_m & 1) ? lvl_m : 0))
    rd_chk(`TPC_IDX_OUT_CTRL, 8'(toc_m));
  endtask
  // match pulse: irq a cycle later, pin a cycle after that
  task automatic match(input logic a, input logic b);
    @(posedge ref_clk_in);
    m0 <= a;
    m1 <= b;
    @(posedge ref_clk_in);
    m0 <= 1'b0;
    m1 <= 1'b0;
    if (run != 2'h0 && a && toc_m[1]) lvl_m ^= 1;
    if (run != 2'h0 && b && toc_m[4]) lvl_m ^= 1;
    #1 `CHK({irq0, irq1}, {a, b} & {2{run != 2'h0}})
    @(posedge ref_clk_in);
    #1 `CHK(tout, 1'((toc_m & 1) ? lvl_m : 0))
  endtask
  initial begin
    #600_000;
    bad_count++;
    $display("ERROR t=%0t watchdog expired", $time);
    summarize();
  end
  // ==========================================================================
  // main sequence
  initial begin
    logic [7:0] d;
    void'($urandom(43));
    repeat (20) @(posedge ref_clk_in);
    rst_n_in <= 1'b1;
    #1 `CHK({tout, oe_n}, 3'b011)
    rd_chk(`TPC_IDX_PORT_DIR, `TPC_RST_PORT_DIR);
    rd_chk(`TPC_IDX_PRESCALE, `TPC_RST_PRESCALE);
    rd_chk(`TPC_IDX_OUT_CTRL, `TPC_RST_OUT_CTRL);
    rd_chk(16'h0123, 8'h00);
    $display("test reset done");
    // high input at first enable counts as a rise, not after a restart
    xfer(1'b1, `TPC_IDX_PRESCALE, 8'h50);
    pins(1'b1);
    clr();
    go(2'h1);
    `CHK({n_e0, n_e1}, {32'd1, 32'd1})
    go(2'h0);
    clr();
    go(2'h1);
    `CHK(n_e0 + n_e1, 0)
    go(2'h0);
    pins(1'b0);
    foreach (d[i]) if (i < 4) begin
      xfer(1'b1, `TPC_IDX_PORT_DIR, 8'($urandom));
      repeat (2) @(posedge ref_clk_in);
      #1 `CHK(oe_n, wd[1:0])
      rd_chk(`TPC_IDX_PORT_DIR, {`TPC_DIR_FIXED, wd[1:0]});
      d = 8'($urandom);
      xfer(1'b1, `TPC_IDX_PRESCALE, d);
      rd_chk(`TPC_IDX_PRESCALE, d & `TPC_PRM_MASK);
    end
    xfer(1'b1, 16'h0123, 8'hff);
    rd_chk(16'h0123, 8'h00);
    $display("test registers done");
    // every edge code on both inputs
    foreach (d[i]) if (i != 2 && i < 4) begin
      xfer(1'b1, `TPC_IDX_PRESCALE, {2'(i), 2'(i), 4'h0});
      go(2'h1);
      clr();
      pins(1'b1);
      `CHK({n_e0, n_e1}, {2{32'(i != 0)}})
      clr();
      pins(1'b0);
      `CHK({n_e0, n_e1}, {2{32'(i != 1)}})
      go(2'h0);
    end
    // count clock: every cycle, every fourth, then input-0 edges
    foreach (d[i]) if (i < 2) begin
      xfer(1'b1, `TPC_IDX_PRESCALE, 8'(i));
      go(2'h1);
      clr();
      repeat (40) @(posedge ref_clk_in);
      `CHK(n_tick, i ? 10 : 40)
      go(2'h0);
      clr();
      repeat (20) @(posedge ref_clk_in);
      `CHK(n_tick, 0)
    end
    xfer(1'b1, `TPC_IDX_PRESCALE, 8'h33);
    go(2'h1);
    clr();
    pins(1'b1);
    pins(1'b0);
    `CHK(n_tick, 2)
    xfer(1'b1, `TPC_IDX_PRESCALE, 8'h00);
    rd_chk(`TPC_IDX_PRESCALE, 8'h33);
    go(2'h0);
    $display("test edges and clock done");
    // output setup order, level triggers, toggles on matches
    wr_toc(8'h12);
    wr_toc(8'h13);
    wr_toc(8'h1b);
    wr_toc(8'h13);
    wr_toc(8'h17);
    wr_toc(8'h1f);
    match(1'b1, 1'b0);
    go(2'h1);
    match(1'b1, 1'b0);
    match(1'b0, 1'b1);
    match(1'b1, 1'b1);
    wr_toc(8'h00);
    match(1'b0, 1'b1);
    wr_toc(8'h1b);
    go(2'h0);
    wr_toc(8'h10);
    $display("test output done");
    // one-shot enable and software trigger
    wr_toc(8'h23);
    `CHK(osm, 1'b1)
    go(2'h1);
    clr();
    wr_toc(8'h63);
    `CHK(n_cs, 1)
    go(2'h0);
    $display("test one-shot done");
    summarize();
  end
endmodule // tb

// >>> design/tpc_cfg.svh
// register indices, field positions, reset values and codes of the timer output block
`ifndef TPC_CFG_SVH
`define TPC_CFG_SVH
// ==========================================================================
// register indices (byte address = 4 * index)
`define TPC_ADDR_W         18
`define TPC_IDX_PORT_DIR   16'hff20
`define TPC_IDX_PRESCALE   16'hffbb
`define TPC_IDX_OUT_CTRL   16'hffbd
// ==========================================================================
// reset values
`define TPC_RST_PORT_DIR   8'hff
`define TPC_RST_PRESCALE   8'h00
`define TPC_RST_OUT_CTRL   8'h00
// ==========================================================================
// output control fields
`define TPC_TOC_OSPT       6
`define TPC_TOC_OSPE       5
`define TPC_TOC_INV1       4
`define TPC_TOC_LVS        3
`define TPC_TOC_LVR        2
`define TPC_TOC_INV0       1
`define TPC_TOC_TOE        0
// ==========================================================================
// prescale fields; bits 3:2 are fixed zero
`define TPC_PRM_ES1_LSB    6
`define TPC_PRM_ES0_LSB    4
`define TPC_PRM_CKS_LSB    0
`define TPC_PRM_MASK       8'hf3
`define TPC_DIR_FIXED      6'h3f
// ==========================================================================
// codes
`define TPC_RUN_STOP       2'h0
`define TPC_RUN_EDGE_CLR   2'h2
`define TPC_RUN_MATCH_CLR  2'h3
`define TPC_EDGE_FALL      2'h0
`define TPC_EDGE_RISE      2'h1
`define TPC_EDGE_BOTH      2'h3
`define TPC_CKS_PCLK       2'h0
`define TPC_CKS_DIV4       2'h1
`define TPC_CKS_IN0        2'h3
`define TPC_DIV4_LAST      2'h3
`endif

// >>> design/tpc_edge_detect.sv
// synchronised, filtered valid-edge detector for one timer input pin
`timescale 1ns/1ps
`include "tpc_cfg.svh"
module tpc_edge_detect (
  input  wire logic ref_clk_in,
  input  wire logic rst_n_in,
  input  wire logic pin_in,
  tpc_edge_if.det   eif
);
  logic [2:0] sync_q;
  logic       level_q;
  logic       prev_q;
  logic       first_q;
  logic       edge_q;
  // ==========================================================================
  // filter: level moves only when second and third stage agree
  wire stable  = (sync_q[1] == sync_q[2]);
  wire level_d = stable ? sync_q[2] : level_q;
  wire rise    = level_q & ~prev_q;
  wire fall    = ~level_q & prev_q;
  wire hit     = ((eif.sel == `TPC_EDGE_RISE) & rise) |
                 ((eif.sel == `TPC_EDGE_FALL) & fall) |
                 ((eif.sel == `TPC_EDGE_BOTH) & (rise | fall));
  // before the first enable prev is held low so a high pin reads as a rise
  wire prev_d  = (!eif.run && first_q) ? 1'b0 : level_q;
  assign eif.edge_hit = edge_q;

  // synchroniser, first stage feeds only the second
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sync_q <= 3'h0;
    end else begin
      sync_q <= {sync_q[1:0], pin_in};
    end
  end

  // edge state; stopped timer detects nothing
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      level_q <= 1'b0;
      prev_q  <= 1'b0;
      first_q <= 1'b1;
      edge_q  <= 1'b0;
    end else begin
      level_q <= level_d;
      prev_q  <= prev_d;
      first_q <= first_q & ~eif.run;
      edge_q  <= eif.run & hit;
    end
  end

  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rst_n_in);
  first_rise_a: assert property ($rose(eif.run) && first_q && level_q &&
    eif.sel == `TPC_EDGE_RISE |=> edge_q) else $error("high level at first enable not a rise");
  stop_quiet_a: assert property (!eif.run |=> !edge_q)
    else $error("edge reported while stopped");
endmodule // tpc_edge_detect

// >>> design/tpc_edge_if.sv
// carrier between the control logic and one input edge detector
`timescale 1ns/1ps
interface tpc_edge_if;
  tpc_pkg::tpc_sel_t sel;
  logic              run;
  logic              edge_hit;
  modport ctrl (output sel, output run, input edge_hit);
  modport det  (input sel, input run, output edge_hit);
endinterface

// >>> design/tpc_pkg.sv
// shared types of the timer output block
package tpc_pkg;
  typedef logic [1:0] tpc_sel_t;
  // stored fields of the output control register
  typedef struct packed {
    logic ospe;
    logic inv1;
    logic inv0;
    logic toe;
  } tpc_toc_s;
endpackage

// >>> design/tpc_timer_out_ctrl.sv
// timer output, prescale/edge select and port direction control with avalon-mm slave
// Functional notes
// - match-1 invert enable is writable while the counter runs.
// - reset clears the output control register to zero.
// - one-shot trigger reads 0; writing 1 clears and starts the counter.
// - one-shot enable picks one-shot output; not in match-0 clear mode.
// - match-1 invert enable toggles output on match 1; irq raised on every match while running.
// - match-0 invert enable toggles output on match 0; irq raised on every match while running.
// - level pair 00 no change, 01 low, 10 high, 11 prohibited.
// - level triggers read 0; writing 0 leaves output unchanged.
// - output enable 0 holds the pin low, 1 follows output logic.
// - prescale register not rewritten while running; reset value zero.
// - input 1 edge select: 00 fall, 01 rise, 11 both.
// - input 0 edge select: 00 fall, 01 rise, 11 both.
// - count clock: 00 peripheral, 01 divided by four, 11 input-0 edges.
// - high input at first enable counts as a rise; not after a restart.
// - direction bit 0 output, 1 input; upper six bits fixed one.
// - run mode 00 stops and clears the internal circuit.
//
// The Avalon-MM register port was chosen for this implementation.
`timescale 1ns/1ps
`include "tpc_cfg.svh"
module tpc_timer_out_ctrl (
  input  wire logic                  ref_clk_in,
  input  wire logic                  rst_n_in,
  // avalon-mm slave, byte address
  input  wire logic [`TPC_ADDR_W-1:0] avs_address_in,
  input  wire logic                  avs_read_in,
  input  wire logic                  avs_write_in,
  input  wire logic [31:0]           avs_writedata_in,
  input  wire logic [3:0]            avs_byteenable_in,
  output logic      [31:0]           avs_readdata_out,
  output logic                       avs_waitrequest_out,
  // counter core
  input  wire logic [1:0]            run_mode_in,
  input  wire logic                  match0_in,
  input  wire logic                  match1_in,
  output logic                       count_tick_out,
  output logic                       counter_clear_start_out,
  output logic                       oneshot_mode_out,
  output logic                       match0_irq_out,
  output logic                       match1_irq_out,
  output logic                       in0_edge_out,
  output logic                       in1_edge_out,
  // pins
  input  wire logic                  timer_in0_pin_in,
  input  wire logic                  timer_in1_pin_in,
  output logic                       timer_out_pin_out,
  output logic [1:0]                 port_oe_n_out
);
  logic               wreq_q;
  logic [31:0]        rdata_q;
  logic [1:0]         dir_q;
  logic [7:0]         prm_q;
  tpc_pkg::tpc_toc_s  toc_q;
  logic               clr_q;
  logic               out_q;
  logic               pin_q;
  logic               armed_q;
  logic [1:0]         div_q;
  logic               tick_q;
  logic               m0_irq_q;
  logic               m1_irq_q;
  tpc_edge_if         in0_if ();
  tpc_edge_if         in1_if ();

  // ==========================================================================
  // bus decode
  wire [15:0] idx      = avs_address_in[`TPC_ADDR_W-1:2];
  wire        sel_dir  = (idx == `TPC_IDX_PORT_DIR);
  wire        sel_prm  = (idx == `TPC_IDX_PRESCALE);
  wire        sel_toc  = (idx == `TPC_IDX_OUT_CTRL);
  wire        req_new  = (avs_read_in | avs_write_in) & wreq_q;
  // a write lands at the edge where waitrequest is seen low
  wire        wr_fire  = avs_write_in & ~wreq_q & avs_byteenable_in[0];
  wire [7:0]  wd       = avs_writedata_in[7:0];
  wire        running  = (run_mode_in != `TPC_RUN_STOP);
  wire        wr_dir   = wr_fire & sel_dir;
  wire        wr_prm   = wr_fire & sel_prm & ~running;
  wire        wr_toc   = wr_fire & sel_toc;
  wire        wr_tocs  = wr_toc & ~running;
  // triggers and fixed bits read as constants
  wire [7:0]  rd_toc   = {2'b00, toc_q.ospe, toc_q.inv1, 2'b00,
                          toc_q.inv0, toc_q.toe};
  wire [7:0]  rd_val   = sel_dir ? {`TPC_DIR_FIXED, dir_q} :
                         sel_prm ? (prm_q & `TPC_PRM_MASK) :
                         sel_toc ? rd_toc : 8'h00;

  // ==========================================================================
  // field views of the prescale register
  wire [1:0] es1 = prm_q[`TPC_PRM_ES1_LSB +: 2];
  wire [1:0] es0 = prm_q[`TPC_PRM_ES0_LSB +: 2];
  wire [1:0] cks = prm_q[`TPC_PRM_CKS_LSB +: 2];
  assign in0_if.sel = es0;
  assign in1_if.sel = es1;
  assign in0_if.run = running;
  assign in1_if.run = running;

  // ==========================================================================
  // output logic terms
  wire lvl_set   = wr_tocs & wd[`TPC_TOC_LVS] & ~wd[`TPC_TOC_LVR];
  wire lvl_clr   = wr_tocs & ~wd[`TPC_TOC_LVS] & wd[`TPC_TOC_LVR];
  wire sw_trig   = wr_toc & wd[`TPC_TOC_OSPT];
  // one-shot has no meaning when match 0 already restarts the count
  wire oneshot   = toc_q.ospe & (run_mode_in != `TPC_RUN_MATCH_CLR);
  wire arm_edge  = (run_mode_in == `TPC_RUN_EDGE_CLR) & in0_if.edge_hit;
  wire tog0      = match0_in & toc_q.inv0;
  wire tog1      = match1_in & toc_q.inv1;
  wire gate      = ~oneshot | armed_q;
  wire flip      = running & gate & (tog0 ^ tog1);
  // a level trigger write beats a toggle in the same cycle
  wire out_d     = lvl_set ? 1'b1 : lvl_clr ? 1'b0 : (flip ? ~out_q : out_q);
  wire armed_d   = (sw_trig | arm_edge) ? 1'b1 :
                   (oneshot & match1_in) ? 1'b0 : armed_q;
  wire [1:0] div_d = running ? div_q + 2'h1 : 2'h0;
  wire tick_d    = running & (((cks == `TPC_CKS_PCLK)) |
                   ((cks == `TPC_CKS_DIV4) & (div_q == `TPC_DIV4_LAST)) |
                   ((cks == `TPC_CKS_IN0) & in0_if.edge_hit));

  // ==========================================================================
  // edge detectors for both timer inputs
  tpc_edge_detect u_in0 (
    .ref_clk_in (ref_clk_in),
    .rst_n_in   (rst_n_in),
    .pin_in     (timer_in0_pin_in),
    .eif        (in0_if.det)
  );
  tpc_edge_detect u_in1 (
    .ref_clk_in (ref_clk_in),
    .rst_n_in   (rst_n_in),
    .pin_in     (timer_in1_pin_in),
    .eif        (in1_if.det)
  );

  // ==========================================================================
  // bus handshake: one wait cycle, read data registered
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wreq_q  <= 1'b1;
      rdata_q <= 32'h0000_0000;
    end else begin
      wreq_q  <= ~req_new;
      if (req_new && avs_read_in) begin
        rdata_q <= {24'h00_0000, rd_val};
      end
    end
  end

  // direction and prescale registers
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      dir_q <= 2'(`TPC_RST_PORT_DIR);
      prm_q <= `TPC_RST_PRESCALE;
    end else begin
      if (wr_dir) begin
        dir_q <= wd[1:0];
      end
      if (wr_prm) begin
        prm_q <= wd & `TPC_PRM_MASK;
      end
    end
  end

  // output control fields; match-1 invert stays writable while running
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      toc_q <= tpc_pkg::tpc_toc_s'(4'h0);
    end else begin
      if (wr_toc) begin
        toc_q.inv1 <= wd[`TPC_TOC_INV1];
      end
      if (wr_tocs) begin
        toc_q.ospe <= wd[`TPC_TOC_OSPE];
        toc_q.inv0 <= wd[`TPC_TOC_INV0];
        toc_q.toe  <= wd[`TPC_TOC_TOE];
      end
    end
  end

  // output level, pin and one-shot arming
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      out_q   <= 1'b0;
      pin_q   <= 1'b0;
      armed_q <= 1'b0;
      clr_q   <= 1'b0;
    end else begin
      out_q   <= out_d;
      pin_q   <= toc_q.toe & out_q;
      armed_q <= armed_d;
      clr_q   <= sw_trig;
    end
  end

  // count clock and interrupt pulses to the core
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      div_q    <= 2'h0;
      tick_q   <= 1'b0;
      m0_irq_q <= 1'b0;
      m1_irq_q <= 1'b0;
    end else begin
      div_q    <= div_d;
      tick_q   <= tick_d;
      m0_irq_q <= running & match0_in;
      m1_irq_q <= running & match1_in;
    end
  end

  // ==========================================================================
  // outputs
  assign avs_readdata_out        = rdata_q;
  assign avs_waitrequest_out     = wreq_q;
  assign count_tick_out          = tick_q;
  assign counter_clear_start_out = clr_q;
  assign oneshot_mode_out        = toc_q.ospe;
  assign match0_irq_out          = m0_irq_q;
  assign match1_irq_out          = m1_irq_q;
  assign in0_edge_out            = in0_if.edge_hit;
  assign in1_edge_out            = in1_if.edge_hit;
  assign timer_out_pin_out       = pin_q;
  assign port_oe_n_out           = dir_q;

  // ==========================================================================
  // checks
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rst_n_in);
  sequence s_ack;
    !avs_waitrequest_out ##1 avs_waitrequest_out;
  endsequence
  bus_ack_a: assert property (req_new |=> s_ack)
    else $error("waitrequest did not drop for exactly one cycle");
  toc_readback_a: assert property (req_new && avs_read_in && sel_toc |=>
    avs_readdata_out[6] == 1'b0 && avs_readdata_out[3:2] == 2'b00)
    else $error("trigger bits read back nonzero");
  dir_readback_a: assert property (req_new && avs_read_in && sel_dir |=>
    avs_readdata_out[7:2] == `TPC_DIR_FIXED) else $error("direction upper bits not one");
  sw_start_a: assert property (sw_trig |=> counter_clear_start_out ##1
    !counter_clear_start_out) else $error("clear-start pulse wrong");
  level_high_a: assert property (lvl_set |=> out_q ##1 (pin_q == toc_q.toe))
    else $error("level set did not drive output high");
  out_gate_a: assert property (!toc_q.toe |=> !timer_out_pin_out)
    else $error("pin not low with output disabled");
  match0_flip_a: assert property (running && tog0 && !tog1 && gate &&
    !lvl_set && !lvl_clr |=> out_q != $past(out_q)) else $error("no toggle on match 0");
  match1_irq_a: assert property (running && match1_in |=> match1_irq_out)
    else $error("match 1 irq missing");
  inv1_live_a: assert property (wr_toc && running |=>
    toc_q.inv1 == $past(wd[`TPC_TOC_INV1])) else $error("match-1 invert write lost");
  prm_frozen_a: assert property (running |=> prm_q == $past(prm_q))
    else $error("prescale changed while running");
  div4_tick_a: assert property (tick_q && cks == `TPC_CKS_DIV4 |=>
    !tick_q [*3]) else $error("divide-by-four tick too close");
  oneshot_gate_a: assert property (oneshot && !armed_q && running &&
    !lvl_set && !lvl_clr |=> out_q == $past(out_q)) else $error("one-shot fired unarmed");
endmodule // tpc_timer_out_ctrl
